// file: rtl/call_clear_compare_ops.sv
// decode and execute of in-page call, clear, clear-watchdog, complement and compares
// How it works
// [RQ1] word with top bits 111 is the in-page call, low 13 bits literal
// [RQ2] call first pushes pc plus one onto the return stack
// [RQ3] call loads literal into pc bits 12..0, upper three kept
// [RQ4] latch gets literal 12..8 low and pc 15..13 high
// [RQ5] call takes two cycles, second a forced nop, no flags change
// [RQ6] 0010 100s plus file address is clear file, no flags change
// [RQ7] clear zeroes the file, and working register too when s is 0
// [RQ8] fixed word 0x0004 is clear watchdog, one cycle
// [RQ9] clear watchdog zeroes counter and postscaler, sets both low-active flags
// [RQ10] 0011 0001 compares file to working register unsigned, skip if equal
// [RQ11] on equal the prefetched word is dropped for a forced nop cycle
// [RQ12] 0011 0010 skips likewise when file exceeds working register unsigned
// [RQ13] complement inverts the file, sets zero flag, d picks destination
//
// Local design decisions: the address map and the Avalon-MM slave port.
module call_clear_compare_ops
    import call_clear_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic stack_push_o,
    output logic [15:0] stack_data_o,
    output logic file_we_o,
    output logic [7:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic watchdog_clear_o
);
    import call_clear_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_EXEC = 4'b0010,
        S_NOP = 4'b0100,
        S_DONE = 4'b1000
    } state_e;

    state_e state_q, state_d;
    logic [1:0] phase_q;
    logic [15:0] instr_q, pc_q, stack_top_q;
    logic [7:0] fdata_q, work_q, latch_q, file_q;
    logic zero_q, timeout_flag_n_q, powerdown_flag_n_q, nop_q;
    logic [31:0] rdata_q;
    logic wait_q, push_q, fwe_q, wdc_q;
    logic [7:0] faddr_q, fwd_q;

    // bus decode; an instruction write stalls until its cycles finish
    // lane 0 alone enables every register write here, so the other lanes' byte enables are ignored
    wire wr_instr = avs_write_i && (avs_address_i == ADDR_INSTR) && avs_byteenable_i[0];
    wire wr_fdata = avs_write_i && (avs_address_i == ADDR_FDATA) && avs_byteenable_i[0];
    wire wr_work = avs_write_i && (avs_address_i == ADDR_WORK) && avs_byteenable_i[0];
    wire wr_pc = avs_write_i && (avs_address_i == ADDR_PC) && avs_byteenable_i[0];
    // a stale push pulse keeps the bus stalled one more cycle
    wire bus_idle = (state_q == S_IDLE) && wait_q && !push_q;

    // instruction class decode
    wire dec_call = instr_q[15:13] == OPC_CALL; // RQ1
    wire dec_clear_file = instr_q[15:9] == OPC_CLEAR_FILE; // RQ6
    wire dec_clear_watchdog = instr_q == OPC_CLEAR_WATCHDOG; // RQ8
    wire dec_invert_file = instr_q[15:9] == OPC_INVERT_FILE; // RQ13
    wire dec_cpseq = instr_q[15:8] == OPC_CPSEQ; // RQ10
    wire dec_cpsgt = instr_q[15:8] == OPC_CPSGT; // RQ12
    wire [7:0] faddr = instr_q[7:0];
    // unsigned subtract f minus w; borrow clear means f >= w
    wire [8:0] diff = {1'b0, fdata_q} - {1'b0, work_q};
    wire f_eq = diff[7:0] == 8'h00; // RQ10
    wire f_gt = !diff[8] && !f_eq; // RQ12
    wire skip = (dec_cpseq && f_eq) || (dec_cpsgt && f_gt) || dec_call; // RQ11 RQ5
    wire [15:0] pc_inc = pc_q + 16'h0001;
    wire [15:0] call_pc = {pc_q[15:13], instr_q[12:0]}; // RQ3
    wire [7:0] comp = ~fdata_q; // RQ13
    wire phase_end = phase_q == 2'(PHASES - 1);

    // next-state: exec spans four phases, skip adds a forced nop cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: if (wr_instr && bus_idle) state_d = S_EXEC;
            S_EXEC: if (phase_end) state_d = skip ? S_NOP : S_DONE;
            S_NOP: if (phase_end) state_d = S_DONE;
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= S_IDLE;
            phase_q <= 2'd0;
        end else begin
            state_q <= state_d;
            phase_q <= (state_q == S_EXEC || state_q == S_NOP) ? phase_q + 2'd1 : 2'd0;
        end
    end

    // architectural state updated at end of the execute cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            instr_q <= RST_PC;
            pc_q <= RST_PC;
            stack_top_q <= RST_PC;
            fdata_q <= RST_BYTE;
            work_q <= RST_BYTE;
            latch_q <= RST_BYTE;
            file_q <= RST_BYTE;
            zero_q <= 1'b0;
            timeout_flag_n_q <= 1'b1;
            powerdown_flag_n_q <= 1'b1;
            nop_q <= 1'b0;
            push_q <= 1'b0;
            fwe_q <= 1'b0;
            wdc_q <= 1'b0;
            faddr_q <= RST_BYTE;
            fwd_q <= RST_BYTE;
        end else begin
            push_q <= 1'b0;
            fwe_q <= 1'b0;
            wdc_q <= 1'b0;
            if (state_q == S_IDLE && wr_instr && bus_idle) instr_q <= avs_writedata_i[15:0];
            if (state_q == S_IDLE && wr_fdata && bus_idle) fdata_q <= avs_writedata_i[7:0];
            if (state_q == S_IDLE && wr_work && bus_idle) work_q <= avs_writedata_i[7:0];
            if (state_q == S_IDLE && wr_pc && bus_idle) pc_q <= avs_writedata_i[15:0];
            nop_q <= (state_q == S_NOP); // RQ11
            if (state_q == S_EXEC && phase_end) begin
                pc_q <= pc_inc;
                if (dec_call) begin
                    stack_top_q <= pc_inc; // RQ2
                    push_q <= 1'b1; // RQ2
                    pc_q <= call_pc; // RQ3
                    latch_q <= {pc_q[15:13], instr_q[12:8]}; // RQ4
                end else if (dec_clear_file) begin
                    fwe_q <= 1'b1; // RQ7
                    faddr_q <= faddr;
                    fwd_q <= RST_BYTE; // RQ7
                    file_q <= RST_BYTE;
                    if (!instr_q[8]) work_q <= RST_BYTE; // RQ7
                end else if (dec_clear_watchdog) begin
                    wdc_q <= 1'b1; // RQ9
                    timeout_flag_n_q <= 1'b1; // RQ9
                    powerdown_flag_n_q <= 1'b1; // RQ9
                end else if (dec_invert_file) begin
                    zero_q <= comp == 8'h00; // RQ13
                    if (instr_q[8]) begin
                        fwe_q <= 1'b1;
                        faddr_q <= faddr;
                        fwd_q <= comp;
                        file_q <= comp;
                    end else begin
                        work_q <= comp;
                    end
                end
            end
            // the call's forced nop must keep the target it just loaded
            if (state_q == S_NOP && phase_end && !dec_call) pc_q <= pc_q + 16'h0001; // RQ11
        end
    end

    // read mux and waitrequest; waitrequest drops one cycle after the request, or after S_DONE for an instruction write
    wire [31:0] rd_mux =
        (avs_address_i == ADDR_INSTR) ? {16'h0000, instr_q} :
        (avs_address_i == ADDR_FDATA) ? {24'h00_0000, fdata_q} :
        (avs_address_i == ADDR_WORK) ? {24'h00_0000, work_q} :
        (avs_address_i == ADDR_PC) ? {16'h0000, pc_q} :
        (avs_address_i == ADDR_STAT) ?
            {28'h000_0000, nop_q, powerdown_flag_n_q, timeout_flag_n_q, zero_q} :
        (avs_address_i == ADDR_FILE) ? {24'h00_0000, file_q} :
        (avs_address_i == ADDR_LATCH) ? {24'h00_0000, latch_q} :
        (avs_address_i == ADDR_STACK_TOP) ? {16'h0000, stack_top_q} : 32'h0000_0000;
    wire req = avs_read_i || avs_write_i;
    wire ack = req && wait_q && bus_idle;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= !(ack && !wr_instr) && !(state_q == S_DONE); // stall while executing
            if (ack) rdata_q <= rd_mux;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign stack_push_o = push_q;
    assign stack_data_o = stack_top_q;
    assign file_we_o = fwe_q;
    assign file_addr_o = faddr_q;
    assign file_wdata_o = fwd_q;
    assign watchdog_clear_o = wdc_q;

    // call pushes return address and forces one nop cycle
    a_call_push: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=> stack_push_o && nop_q == 1'b0)
        else $error("call did not push"); // RQ2
    a_call_nop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=> state_q == S_NOP)
        else $error("call missed forced nop"); // RQ5
    a_call_pc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=>
        pc_q[12:0] == $past(instr_q[12:0]) && pc_q[15:13] == $past(pc_q[15:13]))
        else $error("call pc wrong"); // RQ3
    a_call_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=>
        latch_q == {$past(pc_q[15:13]), $past(instr_q[12:8])})
        else $error("latch wrong"); // RQ4
    a_clr_file: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_clear_file) |=>
        file_we_o && file_wdata_o == 8'h00)
        else $error("clear file missing"); // RQ7
    a_clr_work: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_clear_file && !instr_q[8]) |=> work_q == 8'h00)
        else $error("clear working register missing"); // RQ7
    a_wdt_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_clear_watchdog) |=>
        watchdog_clear_o && timeout_flag_n_q && powerdown_flag_n_q && state_q == S_DONE)
        else $error("watchdog clear wrong"); // RQ9
    a_skip_eq: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_cpseq) |=>
        (state_q == S_NOP) == $past(f_eq))
        else $error("equal skip wrong"); // RQ11
    a_skip_gt: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_cpsgt) |=>
        (state_q == S_NOP) == ($past(fdata_q) > $past(work_q)))
        else $error("greater skip wrong"); // RQ12
    a_comp_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_invert_file) |=>
        zero_q == ($past(fdata_q) == 8'hFF))
        else $error("complement zero flag wrong"); // RQ13

    // the call target must survive its own forced nop cycle
    a_call_target: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_NOP && phase_end && dec_call) |=> pc_q == $past(pc_q))
        else $error("call target lost in nop"); // RQ3
    a_call_stack: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=>
        stack_data_o == $past(pc_q) + 16'h0001)
        else $error("pushed return address wrong"); // RQ2
    a_push_source: assert property (@(posedge clk_i) disable iff (!rstn_i)
        stack_push_o |-> dec_call)
        else $error("push without call"); // RQ2
    a_call_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_call) |=> zero_q == $past(zero_q))
        else $error("call changed a flag"); // RQ5

    // clear keeps its hands off the flags and, with s set, the working register
    a_clr_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_clear_file) |=>
        file_addr_o == $past(instr_q[7:0]) && zero_q == $past(zero_q))
        else $error("clear file address or flag wrong"); // RQ6
    a_clr_keep_work: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_clear_file && instr_q[8]) |=>
        work_q == $past(work_q))
        else $error("clear with s set touched working register"); // RQ7
    a_wdt_source: assert property (@(posedge clk_i) disable iff (!rstn_i)
        watchdog_clear_o |-> dec_clear_watchdog)
        else $error("watchdog clear without its word"); // RQ8

    // compares only steer the flow; the skip nop steps the pc once
    a_cmp_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && (dec_cpseq || dec_cpsgt)) |=>
        zero_q == $past(zero_q) && work_q == $past(work_q))
        else $error("compare changed state"); // RQ10
    a_skip_pc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_NOP && phase_end && !dec_call) |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("skip nop pc step wrong"); // RQ11

    // complement result goes to exactly one destination
    a_comp_to_work: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_invert_file && !instr_q[8]) |=>
        work_q == ~$past(fdata_q) && !file_we_o)
        else $error("complement to working register wrong"); // RQ13
    a_comp_to_file: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_q == S_EXEC && phase_end && dec_invert_file && instr_q[8]) |=>
        file_we_o && file_wdata_o == ~$past(fdata_q) && work_q == $past(work_q))
        else $error("complement to file wrong"); // RQ13
endmodule

// file: rtl/call_clear_pkg.sv
// constants for the call, clear, complement and compare decoder
package call_clear_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // bus map, word aligned byte addresses
    localparam logic [4:0] ADDR_INSTR = 5'h00;
    localparam logic [4:0] ADDR_FDATA = 5'h04;
    localparam logic [4:0] ADDR_WORK = 5'h08;
    localparam logic [4:0] ADDR_PC = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h10;
    localparam logic [4:0] ADDR_FILE = 5'h14;
    localparam logic [4:0] ADDR_LATCH = 5'h18;
    localparam logic [4:0] ADDR_STACK_TOP = 5'h1C;
    // opcode patterns
    localparam logic [2:0] OPC_CALL = 3'h7;
    localparam logic [6:0] OPC_CLEAR_FILE = 7'h14;
    localparam logic [6:0] OPC_INVERT_FILE = 7'h09;
    localparam logic [7:0] OPC_CPSEQ = 8'h31;
    localparam logic [7:0] OPC_CPSGT = 8'h32;
    localparam logic [15:0] OPC_CLEAR_WATCHDOG = 16'h0004;
    // reset values
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // status bit positions: zero, timeout_n, powerdown_n, skip pending
    localparam int unsigned ST_ZERO = 0;
    localparam int unsigned ST_TIMEOUT_N = 1;
    localparam int unsigned ST_POWERDOWN_N = 2;
    localparam int unsigned ST_NOP = 3;
    // cycles of the decode engine per instruction cycle (four phases)
    localparam int unsigned PHASES = 4;
endpackage

// file: sim/tb_top.sv
// self-checking bench for the call, clear, complement and compare decoder
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import call_clear_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, rd;
    logic avs_waitrequest_o, stack_push_o, file_we_o, watchdog_clear_o;
    logic [15:0] stack_data_o, pushed_q, fw_q;
    logic [7:0] file_addr_o, file_wdata_o;
    int failures = 0;
    int tests_run = 0;
    int pushes = 0;
    int wd_clears = 0;
    int file_writes = 0;
    int lat, base_lat;
    // compare table: opcode, file value, working value, skip expected
    logic [24:0] cmp_tab [7] = '{{8'h31, 8'h40, 8'h40, 1'b1}, {8'h31, 8'h41, 8'h40, 1'b0},
        {8'h32, 8'h41, 8'h40, 1'b1}, {8'h32, 8'h40, 8'h40, 1'b0}, {8'h32, 8'h3f, 8'h40, 1'b0},
        {8'h32, 8'hff, 8'h00, 1'b1}, {8'h31, 8'h00, 8'hff, 1'b0}};

    call_clear_compare_ops DUT (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .stack_push_o(stack_push_o),
        .stack_data_o(stack_data_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
        .file_wdata_o(file_wdata_o), .watchdog_clear_o(watchdog_clear_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // pulses stand one cycle, so count and capture them at every edge
    always @(posedge clk_i) begin
        if (stack_push_o === 1'b1) begin
            pushes++;
            pushed_q = stack_data_o;
        end
        if (file_we_o === 1'b1) begin
            file_writes++;
            fw_q = {file_addr_o, file_wdata_o};
        end
        if (watchdog_clear_o === 1'b1) wd_clears++;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle; held until waitrequest is seen low, latency kept in lat
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (avs_waitrequest_o !== 1'b0 && lat < 500);
        if (lat >= 500) failures++;
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask

    // load pc, working value and file operand, then issue one word
    task automatic run(input logic [15:0] pc, input logic [7:0] w, input logic [7:0] f,
                       input logic [15:0] ins);
        access(1'b1, ADDR_PC, {16'h0000, pc});
        access(1'b1, ADDR_WORK, {24'h00_0000, w});
        access(1'b1, ADDR_FDATA, {24'h00_0000, f});
        access(1'b1, ADDR_INSTR, {16'h0000, ins});
    endtask

    task automatic call_case(input logic [15:0] pc, input logic [12:0] k);
        run(pc, 8'h00, 8'h00, {3'b111, k});
        chk("call lat", lat, base_lat + PHASES);
        chk("push data", pushed_q, 16'(pc + 16'h0001));
        rdchk("stack top", ADDR_STACK_TOP, {16'h0000, pc + 16'h0001});
        rdchk("call pc", ADDR_PC, {16'h0000, pc[15:13], k});
        rdchk("latch", ADDR_LATCH, {24'h00_0000, pc[15:13], k[12:8]});
        access(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("call flags", rd[2:0], 3'b111);
    endtask

    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        failures++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk("status rst", ADDR_STAT, 32'h0000_0006);
        rdchk("pc rst", ADDR_PC, 32'h0000_0000);
        rdchk("unmapped", 5'h02, 32'h0000_0000);
        // a write without lane 0 must leave the register alone
        access(1'b1, ADDR_WORK, 32'h0000_0011);
        avs_byteenable_i <= 4'he;
        access(1'b1, ADDR_WORK, 32'h0000_0022);
        avs_byteenable_i <= 4'hf;
        rdchk("work lane", ADDR_WORK, 32'h0000_0011);
        run(16'h0100, 8'h77, 8'h5a, 16'h2833);
        base_lat = lat;
        chk("clr file", fw_q, 16'h3300);
        rdchk("clr work", ADDR_WORK, 32'h0000_0000);
        rdchk("clr flags", ADDR_STAT, 32'h0000_0006);
        run(16'h0100, 8'h77, 8'h5a, 16'h2944);
        chk("clr s1 file", fw_q, 16'h4400);
        rdchk("clr s1 work", ADDR_WORK, 32'h0000_0077);
        run(16'h0000, 8'h00, 8'h13, 16'h1255);
        rdchk("inv work", ADDR_WORK, 32'h0000_00ec);
        rdchk("inv zero0", ADDR_STAT, 32'h0000_0006);
        run(16'h0000, 8'h00, 8'hff, 16'h1366);
        chk("inv file", fw_q, 16'h6600);
        rdchk("inv zero1", ADDR_STAT, 32'h0000_0007);
        run(16'h0000, 8'h00, 8'h00, OPC_CLEAR_WATCHDOG);
        chk("wd lat", lat, base_lat);
        chk("wd pulse", wd_clears, 1);
        rdchk("wd flags", ADDR_STAT, 32'h0000_0007);
        // skip costs one extra instruction cycle and one extra pc step
        foreach (cmp_tab[i]) begin
            run(16'h0200, cmp_tab[i][8:1], cmp_tab[i][16:9], {cmp_tab[i][24:17], 8'h05});
            chk("cmp lat", lat, base_lat + PHASES * cmp_tab[i][0]);
            rdchk("cmp pc", ADDR_PC, 32'h0000_0201 + cmp_tab[i][0]);
            access(1'b0, ADDR_STAT, 32'h0000_0000);
            chk("cmp flags", rd[2:0], 3'b111);
        end
        call_case(16'ha123, 13'h1abc);
        call_case(16'hffff, 13'h0000);
        chk("pushes", pushes, 2);
        chk("file writes", file_writes, 3);
        wrap_up();
    end
endmodule
